// [sram_port_pkg.sv]
// Shared constants, types and helpers for the burst SRAM port and its controller
package sram_port_pkg;

  // Organisation: 18-bit words with two 9-bit byte lanes.
  // An 8-bit part is DATA_W 8 / SEL_W 2, a 9-bit part is DATA_W 9 / SEL_W 1.
  localparam int DATA_W       = 18;
  localparam int SEL_W        = 2;
  localparam int LANE_W       = DATA_W / SEL_W;
  localparam int ADDR_W       = 8;
  localparam int BURST        = 4;
  localparam int MEM_WORDS    = 1 << ADDR_W;

  // Beats are core_clk cycles with the link clock running; two beats per link cycle.
  // Read: first word registered five beats after the start; write: first word two beats after.
  localparam int RD_LAT_BEATS = 5;
  localparam int WR_LAT_BEATS = 2;
  localparam int RD_SR_W      = RD_LAT_BEATS + BURST;
  localparam int WR_SR_W      = WR_LAT_BEATS + BURST - 1;
  localparam int RSP_DEPTH    = 2;

  typedef logic [DATA_W-1:0]            word_t;
  typedef logic [SEL_W-1:0]             sel_t;
  typedef logic [ADDR_W-1:0]            addr_t;
  typedef logic [1:0]                   idx_t;
  typedef logic [BURST-1:0][DATA_W-1:0] burst_t;
  typedef logic [BURST-1:0][SEL_W-1:0]  bsel_t;

  localparam idx_t  FIRST_IDX     = 2'h1;
  localparam idx_t  LAST_IDX      = 2'h3;
  localparam logic  RST_SELECT_N  = 1'b1;
  localparam logic  RST_Q_OE_N    = 1'b1;
  localparam sel_t  RST_WSEL_N    = {SEL_W{1'b1}};
  localparam logic [2:0] RSP_CREDITS = 3'h2;

  // Active-low lane selects expanded to a per-bit write mask
  function automatic word_t sel_mask(input sel_t sel_n);
    word_t m;
    m = '0;
    for (int i = 0; i < DATA_W; i++) begin
      m[i] = ~sel_n[i / LANE_W];
    end
    return m;
  endfunction

endpackage

// [sram_link_if.sv]
// Pin-level link between the memory controller and the burst SRAM port
interface sram_link_if;
  import sram_port_pkg::*;

  logic  clk_run;
  logic  k_phase;
  addr_t addr;
  logic  read_port_select_n;
  logic  write_port_select_n;
  word_t d;
  sel_t  byte_write_select_n;
  word_t q;
  logic  q_oe_n;

  modport device (
    input  clk_run,
    input  k_phase,
    input  addr,
    input  read_port_select_n,
    input  write_port_select_n,
    input  d,
    input  byte_write_select_n,
    output q,
    output q_oe_n
  );

  modport controller (
    output clk_run,
    output k_phase,
    output addr,
    output read_port_select_n,
    output write_port_select_n,
    output d,
    output byte_write_select_n,
    input  q,
    input  q_oe_n
  );

endinterface

// [sram_port_device.sv]
// Burst SRAM device end: separate read and write ports, four-word double-rate bursts
//
// Behaviour
// - Write starts on low write select, data follows
// - Read data first word 2.5 cycles after start
// - Power-up deselected, read outputs high impedance
// - Burst addresses A, A+1, A+2, A+3
// - Data taken and driven on both edges
// - Select ignored right after its own start
// - No same-type start on consecutive rises
// - Lane selects may change every data edge
// - 18-bit: lanes are bits 8:0, 17:9
// - 8-bit: lanes are bits 3:0, 7:4
// - 9-bit: single select guards bits 8:0
// - All selects high: word not written
// - Stopped link clock holds all state
// - Both selects from idle alternate, read first
module sram_port_device (
  input  wire logic   core_clk,
  input  wire logic   arst_n,
  sram_link_if.device link
);
  import sram_port_pkg::*;

  typedef struct packed {
    logic                    last_rd;
    logic                    last_wr;
    logic [RD_LAT_BEATS-1:0] rd_v;
    addr_t [RD_LAT_BEATS-1:0] rd_a;
    logic [WR_LAT_BEATS-1:0] wr_v;
    addr_t [WR_LAT_BEATS-1:0] wr_a;
    logic                    wb_act;
    addr_t                   wb_a;
    idx_t                    wb_idx;
    logic                    ob_act;
    addr_t                   ob_a;
    idx_t                    ob_idx;
    word_t                   q;
    logic                    q_oe_n;
  } dev_s;

  dev_s  s_q;
  dev_s  s_d;
  word_t mem [MEM_WORDS];
  logic  mem_we;
  addr_t mem_wa;
  word_t mem_wm;
  addr_t rd_ra;
  word_t rd_word;
  logic  rd_pop;
  logic  wr_pop;
  logic  rd_ok;
  logic  wr_ok;

  // Start arbitration only at positive-phase beats; no reset pin on the part,
  // arst_n stands in for power-up
  assign rd_ok  = !link.read_port_select_n && !s_q.last_rd;
  assign wr_ok  = !link.write_port_select_n && !s_q.last_wr;
  assign rd_pop = s_q.rd_v[RD_LAT_BEATS-1];
  assign wr_pop = s_q.wr_v[WR_LAT_BEATS-1];

  // Burst word addresses step from the latched start and wrap inside the array
  assign rd_ra = rd_pop ? s_q.rd_a[RD_LAT_BEATS-1] : addr_t'(s_q.ob_a + addr_t'(s_q.ob_idx));
  assign mem_wa = wr_pop ? s_q.wr_a[WR_LAT_BEATS-1] : addr_t'(s_q.wb_a + addr_t'(s_q.wb_idx));
  assign mem_wm = sel_mask(link.byte_write_select_n);
  assign rd_word = mem[rd_ra];

  always_comb begin
    s_d    = s_q;
    mem_we = 1'b0;
    if (link.clk_run) begin
      s_d.rd_v = {s_q.rd_v[RD_LAT_BEATS-2:0], 1'b0};
      s_d.rd_a = {s_q.rd_a[RD_LAT_BEATS-2:0], link.addr};
      s_d.wr_v = {s_q.wr_v[WR_LAT_BEATS-2:0], 1'b0};
      s_d.wr_a = {s_q.wr_a[WR_LAT_BEATS-2:0], link.addr};
      if (link.k_phase) begin
        // Read wins from idle; the previous start's type yields next time
        s_d.rd_v[0] = rd_ok;
        s_d.wr_v[0] = wr_ok && !rd_ok;
        s_d.last_rd = rd_ok;
        s_d.last_wr = wr_ok && !rd_ok;
      end
      // Write data is taken on every beat of its burst
      if (wr_pop) begin
        mem_we     = 1'b1;
        s_d.wb_act = 1'b1;
        s_d.wb_a   = s_q.wr_a[WR_LAT_BEATS-1];
        s_d.wb_idx = FIRST_IDX;
      end else if (s_q.wb_act) begin
        mem_we     = 1'b1;
        s_d.wb_idx = idx_t'(s_q.wb_idx + 2'h1);
        s_d.wb_act = (s_q.wb_idx != LAST_IDX);
      end
      // Read data driven on every beat; released after the last word
      if (rd_pop) begin
        s_d.q      = rd_word;
        s_d.q_oe_n = 1'b0;
        s_d.ob_act = 1'b1;
        s_d.ob_a   = s_q.rd_a[RD_LAT_BEATS-1];
        s_d.ob_idx = FIRST_IDX;
      end else if (s_q.ob_act) begin
        s_d.q      = rd_word;
        s_d.ob_idx = idx_t'(s_q.ob_idx + 2'h1);
        s_d.ob_act = (s_q.ob_idx != LAST_IDX);
      end else begin
        s_d.q_oe_n = RST_Q_OE_N;
      end
    end
  end

  // Lanes with a high select keep their stored bits
  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= (mem[mem_wa] & ~mem_wm) | (link.d & mem_wm);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q        <= '0;
      s_q.q_oe_n <= RST_Q_OE_N;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.q      = s_q.q;
  assign link.q_oe_n = s_q.q_oe_n;

endmodule

// [sram_port_controller.sv]
// Memory controller end: issues bursts, drives the link clock, buffers read bursts
module sram_port_controller (
  input  wire logic                   core_clk,
  input  wire logic                   arst_n,
  input  wire logic                   clock_stop,
  input  wire logic                   cmd_valid,
  output logic                        cmd_ready,
  input  wire logic                   cmd_write,
  input  wire sram_port_pkg::addr_t   cmd_addr,
  input  wire sram_port_pkg::burst_t  cmd_wdata,
  input  wire sram_port_pkg::bsel_t   cmd_wsel_n,
  output logic                        rsp_valid,
  input  wire logic                   rsp_ready,
  output sram_port_pkg::burst_t       rsp_data,
  sram_link_if.controller             link
);
  import sram_port_pkg::*;

  typedef struct packed {
    logic               run;
    logic               k;
    logic               rps_n;
    logic               wps_n;
    addr_t              addr;
    word_t              d;
    sel_t               wsel_n;
    logic               cq_v;
    logic               cq_wr;
    addr_t              cq_a;
    burst_t             cq_wd;
    bsel_t              cq_ws;
    logic               cmd_ready;
    logic               last_rd;
    logic               last_wr;
    logic [WR_SR_W-1:0] wr_sr;
    burst_t             wp_wd;
    bsel_t              wp_ws;
    burst_t             ws_wd;
    bsel_t              ws_ws;
    logic [RD_SR_W-1:0] rd_sr;
    burst_t             rbuf;
    logic [1:0]         rd_out;
    logic               head_v;
    burst_t             head_dat;
    logic               skid_v;
    burst_t             skid_dat;
  } ctl_s;

  ctl_s   c_q;
  ctl_s   c_d;
  logic   idle;
  logic   credit;
  logic   nxt_k;
  logic   push;
  logic   iss_rd;
  burst_t push_dat;

  assign idle   = (c_q.rd_out == 2'h0) && (c_q.wr_sr == '0);
  // A read is only issued when its whole burst has a buffer slot waiting
  assign credit = (3'(c_q.rd_out) + 3'(c_q.head_v) + 3'(c_q.skid_v)) < RSP_CREDITS;

  always_comb begin
    c_d      = c_q;
    push     = 1'b0;
    iss_rd   = 1'b0;
    push_dat = c_q.rbuf;
    // Stop only after a negative beat with nothing in flight
    if (!c_q.run) begin
      c_d.run = !clock_stop;
    end else if (clock_stop && !c_q.k && idle) begin
      c_d.run = 1'b0;
    end
    c_d.k = c_d.run ? ~c_q.k : c_q.k;
    nxt_k = c_d.run && c_d.k;
    if (c_q.run) begin
      c_d.wr_sr  = {c_q.wr_sr[WR_SR_W-2:0], c_q.k && !c_q.wps_n};
      c_d.rd_sr  = {c_q.rd_sr[RD_SR_W-2:0], c_q.k && !c_q.rps_n};
      c_d.wsel_n = RST_WSEL_N;
      if (c_q.k) begin
        c_d.rps_n = RST_SELECT_N;
        c_d.wps_n = RST_SELECT_N;
      end
      // Write words on the two link cycles after the start, one per beat
      if (c_q.wr_sr[0]) begin
        c_d.d      = c_q.wp_wd[0];
        c_d.wsel_n = c_q.wp_ws[0];
        c_d.ws_wd  = c_q.wp_wd;
        c_d.ws_ws  = c_q.wp_ws;
      end
      for (int i = 1; i < BURST; i++) begin
        if (c_q.wr_sr[i]) begin
          c_d.d      = c_q.ws_wd[i];
          c_d.wsel_n = c_q.ws_ws[i];
        end
      end
      for (int i = 0; i < BURST; i++) begin
        if (c_q.rd_sr[RD_LAT_BEATS+i]) begin
          c_d.rbuf[i] = link.q;
        end
      end
      push = c_q.rd_sr[RD_SR_W-1];
      push_dat[BURST-1] = link.q;
    end
    if (nxt_k) begin
      c_d.last_rd = 1'b0;
      c_d.last_wr = 1'b0;
      if (c_q.cq_v && !c_q.cq_wr && !c_q.last_rd && credit) begin
        iss_rd      = 1'b1;
        c_d.rps_n   = 1'b0;
        c_d.addr    = c_q.cq_a;
        c_d.cq_v    = 1'b0;
        c_d.last_rd = 1'b1;
      end else if (c_q.cq_v && c_q.cq_wr && !c_q.last_wr) begin
        c_d.wps_n   = 1'b0;
        c_d.addr    = c_q.cq_a;
        c_d.wp_wd   = c_q.cq_wd;
        c_d.wp_ws   = c_q.cq_ws;
        c_d.cq_v    = 1'b0;
        c_d.last_wr = 1'b1;
      end
    end
    c_d.rd_out = 2'(c_q.rd_out + 2'(iss_rd) - 2'(push));
    if (cmd_valid && c_q.cmd_ready) begin
      c_d.cq_v  = 1'b1;
      c_d.cq_wr = cmd_write;
      c_d.cq_a  = cmd_addr;
      c_d.cq_wd = cmd_wdata;
      c_d.cq_ws = cmd_wsel_n;
    end
    c_d.cmd_ready = !c_d.cq_v;
    // Two-entry response buffer: head register plus skid register
    if (c_q.head_v && rsp_ready) begin
      c_d.head_v   = c_q.skid_v;
      c_d.head_dat = c_q.skid_dat;
      c_d.skid_v   = 1'b0;
    end
    if (push) begin
      if (!c_d.head_v) begin
        c_d.head_v   = 1'b1;
        c_d.head_dat = push_dat;
      end else begin
        c_d.skid_v   = 1'b1;
        c_d.skid_dat = push_dat;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      c_q        <= '0;
      c_q.rps_n  <= RST_SELECT_N;
      c_q.wps_n  <= RST_SELECT_N;
      c_q.wsel_n <= RST_WSEL_N;
    end else begin
      c_q <= c_d;
    end
  end

  assign link.clk_run             = c_q.run;
  assign link.k_phase             = c_q.k;
  assign link.addr                = c_q.addr;
  assign link.read_port_select_n  = c_q.rps_n;
  assign link.write_port_select_n = c_q.wps_n;
  assign link.d                   = c_q.d;
  assign link.byte_write_select_n = c_q.wsel_n;
  assign cmd_ready                = c_q.cmd_ready;
  assign rsp_valid                = c_q.head_v;
  assign rsp_data                 = c_q.head_dat;

endmodule

// [sram_port_asserts.sv]
// Link protocol assertions for the controller and burst SRAM port pair
module sram_port_asserts (
  input wire logic                 core_clk,
  input wire logic                 arst_n,
  input wire logic                 clk_run,
  input wire logic                 k_phase,
  input wire logic                 read_port_select_n,
  input wire logic                 write_port_select_n,
  input wire sram_port_pkg::sel_t  byte_write_select_n,
  input wire sram_port_pkg::word_t q,
  input wire logic                 q_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  import sram_port_pkg::*;
  logic       rd_go;
  logic       wr_go;
  logic [9:0] rd_hist_q;
  logic [9:0] wr_hist_q;
  assign rd_go = clk_run && k_phase && !read_port_select_n;
  assign wr_go = clk_run && k_phase && !write_port_select_n;
  // Start history; the link clock never stops with a burst in flight
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_hist_q <= '0;
      wr_hist_q <= '0;
    end else begin
      rd_hist_q <= {rd_hist_q[8:0], rd_go};
      wr_hist_q <= {wr_hist_q[8:0], wr_go};
    end
  end
  default clocking dcb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence next_k_s;
    clk_run ##1 (clk_run && k_phase);
  endsequence
  sequence rd_words_s;
    (!q_oe_n) [*4];
  endsequence
  rd_spacing_a: assert property (rd_go ##1 next_k_s |-> read_port_select_n)
    else $error("reads on consecutive positive beats");
  wr_spacing_a: assert property (wr_go ##1 next_k_s |-> write_port_select_n)
    else $error("writes on consecutive positive beats");
  rd_latency_a: assert property (rd_go |-> ##6 rd_words_s)
    else $error("read words not driven on time");
  q_idle_off_a: assert property (!q_oe_n |-> |rd_hist_q[8:5])
    else $error("read outputs driven outside a burst");
  wsel_window_a: assert property (byte_write_select_n != RST_WSEL_N |-> |wr_hist_q[4:1])
    else $error("lane selects active outside write data");
  phase_toggle_a: assert property (clk_run && $past(clk_run) |-> k_phase != $past(k_phase))
    else $error("beat phase did not alternate");
  select_k_only_a: assert property (!read_port_select_n || !write_port_select_n |-> clk_run && k_phase)
    else $error("port select low off a positive beat");
  stop_hold_a: assert property (!clk_run ##1 !clk_run |-> $stable(q) && $stable(q_oe_n))
    else $error("outputs moved with link clock stopped");
endmodule

// [test_quad_rate_burst_sram_port.sv]
// Bench: controller and burst SRAM port back to back, random and corner traffic
module test_quad_rate_burst_sram_port;
  timeunit 1ns;
  timeprecision 100ps;
  import sram_port_pkg::*;
  logic        core_clk;
  logic        arst_n;
  logic        clock_stop;
  logic        cmd_valid;
  logic        cmd_ready;
  logic        cmd_write;
  addr_t       cmd_addr;
  burst_t      cmd_wdata;
  bsel_t       cmd_wsel_n;
  logic        rsp_valid;
  logic        rsp_ready;
  burst_t      rsp_data;
  word_t       mem_m [MEM_WORDS];
  burst_t      exp_q [$];
  logic [31:0] lfsr_q;
  logic [31:0] lfsr2_q;
  int          num_errors;
  int          checks;
  int          stall_n;
  logic        prev_wr;
  addr_t       prev_a;
  sram_link_if link_bus ();
  sram_port_controller sram_port_controller_inst (.core_clk, .arst_n, .clock_stop, .cmd_valid, .cmd_ready,
    .cmd_write, .cmd_addr, .cmd_wdata, .cmd_wsel_n, .rsp_valid, .rsp_ready, .rsp_data, .link(link_bus));
  sram_port_device sram_port_device_inst (.core_clk, .arst_n, .link(link_bus));
  sram_port_asserts sram_port_asserts_inst (.core_clk, .arst_n, .clk_run(link_bus.clk_run),
    .k_phase(link_bus.k_phase), .read_port_select_n(link_bus.read_port_select_n),
    .write_port_select_n(link_bus.write_port_select_n), .byte_write_select_n(link_bus.byte_write_select_n),
    .q(link_bus.q), .q_oe_n(link_bus.q_oe_n));
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input burst_t seen, input burst_t exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (num_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic timeout();
    num_errors++;
    $display("Error at %0t: wait ran out", $time);
    print_verdict();
  endtask
  // Entered at a falling edge; the model is updated in issue order
  task automatic send(input logic wr, input addr_t a, input bsel_t ws);
    int     n;
    addr_t  ai;
    burst_t eb;
    for (int i = 0; i < BURST; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      eb[i] = lfsr_q[DATA_W-1:0];
    end
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_addr = a;
    cmd_wdata = eb;
    cmd_wsel_n = ws;
    for (int i = 0; i < BURST; i++) begin
      ai = a + addr_t'(i);
      for (int b = 0; b < DATA_W; b++) begin
        if (wr && !ws[i][b / LANE_W]) mem_m[ai][b] = eb[i][b];
      end
      eb[i] = mem_m[ai];
    end
    if (!wr) exp_q.push_back(eb);
    n = 0;
    while (cmd_ready !== 1'b1 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    // Judge by the condition itself so a late ready on the last try still counts
    if (cmd_ready !== 1'b1) timeout();
    @(negedge core_clk);
  endtask
  task automatic drain();
    int n;
    n = 0;
    cmd_valid = 1'b0;
    while ((exp_q.size() != 0 || cmd_ready !== 1'b1) && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
    if (exp_q.size() != 0 || cmd_ready !== 1'b1) timeout();
  endtask
  task automatic pause();
    drain();
    clock_stop = 1'b1;
    repeat (20) @(negedge core_clk);
    clock_stop = 1'b0;
  endtask
  always @(negedge core_clk) begin
    lfsr2_q = lfsr_next(lfsr2_q);
    rsp_ready = (stall_n == 0) && lfsr2_q[0];
    if (stall_n > 0) stall_n--;
    if (rsp_valid === 1'b1 && rsp_ready) check(rsp_data, (exp_q.size() > 0) ? exp_q.pop_front() : 'x);
  end
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    arst_n = 1'b0;
    clock_stop = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = '0;
    cmd_wdata = '0;
    cmd_wsel_n = '1;
    lfsr_q = 32'h000146c4;
    lfsr2_q = 32'h000146c4;
    num_errors = 0;
    checks = 0;
    stall_n = 0;
    prev_wr = 1'b1;
    prev_a = '0;
    repeat (16) @(negedge core_clk);
    check(burst_t'(link_bus.q_oe_n), burst_t'(RST_Q_OE_N));
    check(burst_t'({link_bus.read_port_select_n, link_bus.write_port_select_n}), burst_t'(2'h3));
    arst_n = 1'b1;
    @(negedge core_clk);
    // Whole array written first so no read meets an unset word
    for (int i = 0; i < MEM_WORDS; i += BURST) send(1'b1, addr_t'(i), '0);
    // Receiver stalls while reads queue behind the two-entry buffer
    stall_n = 80;
    for (int i = 0; i < 12; i++) send(1'b0, addr_t'(i * 21), '1);
    drain();
    // Lane pattern changes every word, across the address wrap
    send(1'b1, 8'hfe, {2'h3, 2'h1, 2'h2, 2'h0});
    send(1'b0, 8'hfe, '1);
    pause();
    for (int k = 0; k < 400; k++) begin
      lfsr_q = lfsr_next(lfsr_q);
      // A write overtaking a pending read of the same words would race it
      if (lfsr_q[31] && !prev_wr && addr_t'(lfsr_q[7:0] - prev_a + 8'h03) < 8'h07) drain();
      prev_wr = lfsr_q[31];
      prev_a = lfsr_q[7:0];
      send(prev_wr, prev_a, bsel_t'(lfsr_q[15:8]));
      if (lfsr_q[20:16] == 5'h00) pause();
    end
    drain();
    print_verdict();
  end
endmodule
